// >>> udoc_top.v
// USB device enable sequencing registers and on-the-go pull control.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "udoc_defs.vh"
module udoc_top #(
  parameter AW = 12
) (
  // APB clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Event inputs from the transfer engine and the VBUS presence level, asynchronous to pclk.
  input wire [7:0] usb_event_in,
  input wire [7:0] usb_err_event_in,
  input wire vbus_present_in,
  // Pull network and supply discharge controls.
  output reg dplus_pullup_en,
  output reg dminus_pullup_en,
  output reg dplus_pulldown_en,
  output reg dminus_pulldown_en,
  output reg vbus_discharge_en,
  // Engine controls.
  output reg pingpong_ptr_reset,
  output reg usb_module_on,
  output reg usb_power_on,
  output reg endpoint_rx_allow,
  output reg endpoint_handshake_on,
  // Interrupt.
  output reg usb_irq
);
  reg [7:0] ctrl_q;
  reg [7:0] otg_q;
  reg [7:0] ien_q;
  reg [7:0] eien_q;
  reg [7:0] iflg_q;
  reg [7:0] eiflg_q;
  reg [7:0] ep0_q;
  reg [7:0] pwr_q;
  reg [16:0] sy1_q;
  reg [16:0] sy2_q;
  reg [31:0] rd_d;
  reg err_d;
  wire acc;
  wire wr;
  wire [7:0] w8;
  wire sw;
  wire pu_dp;
  wire pu_dm;
  wire pd_dp;
  wire pd_dm;

  function [7:0] udoc_w1c;
    input [7:0] flags;
    input [7:0] events;
    input clr_en;
    input [7:0] clr;
    begin
      udoc_w1c = (flags & ~(clr_en ? clr : `UDOC_RST8)) | events;
    end
  endfunction

  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign w8 = pwdata[7:0];

  // Bring-up order is kept by software; the flag registers make step 3 work.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1_q <= 17'h00000;
      sy2_q <= 17'h00000;
    end else begin
      sy1_q <= {vbus_present_in, usb_err_event_in, usb_event_in};
      sy2_q <= sy1_q;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `UDOC_RST8;
      otg_q <= `UDOC_RST8;
      ien_q <= `UDOC_RST8;
      eien_q <= `UDOC_RST8;
      iflg_q <= `UDOC_RST8;
      eiflg_q <= `UDOC_RST8;
      ep0_q <= `UDOC_RST8;
      pwr_q <= `UDOC_RST8;
    end else begin
      // Set wins over a simultaneous write-one clear.
      iflg_q <= udoc_w1c(iflg_q, sy2_q[7:0], wr && paddr == `UDOC_OFF_IFLG, w8);
      eiflg_q <= udoc_w1c(eiflg_q, sy2_q[15:8], wr && paddr == `UDOC_OFF_EIFLG, w8);
      if (wr) begin
        if (paddr == `UDOC_OFF_CTRL) begin
          ctrl_q <= w8;
        end else if (paddr == `UDOC_OFF_OTG) begin
          otg_q <= w8 & `UDOC_OTG_WMASK;
        end else if (paddr == `UDOC_OFF_IEN) begin
          ien_q <= w8;
        end else if (paddr == `UDOC_OFF_EIEN) begin
          eien_q <= w8;
        end else if (paddr == `UDOC_OFF_EP0) begin
          ep0_q <= w8;
        end else if (paddr == `UDOC_OFF_PWR) begin
          pwr_q <= w8;
        end
      end
    end
  end

  // Hardware pull choice: host enables both pull-downs, device the D+ pull-up.
  assign sw = otg_q[`UDOC_OTG_OTG_FEATURES_ON];
  assign pu_dp = sw ? otg_q[`UDOC_OTG_DPPU] : (ctrl_q[`UDOC_CTRL_ON] & ~ctrl_q[`UDOC_CTRL_HOST]);
  assign pu_dm = sw ? otg_q[`UDOC_OTG_DMPU] : 1'b0;
  assign pd_dp = sw ? otg_q[`UDOC_OTG_DPPD] : (ctrl_q[`UDOC_CTRL_ON] & ctrl_q[`UDOC_CTRL_HOST]);
  assign pd_dm = sw ? otg_q[`UDOC_OTG_DMPD] : (ctrl_q[`UDOC_CTRL_ON] & ctrl_q[`UDOC_CTRL_HOST]);

  always @* begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    if (paddr == `UDOC_OFF_CTRL) begin
      rd_d[7:0] = ctrl_q;
    end else if (paddr == `UDOC_OFF_OTG) begin
      rd_d[7:0] = otg_q;
    end else if (paddr == `UDOC_OFF_IEN) begin
      rd_d[7:0] = ien_q;
    end else if (paddr == `UDOC_OFF_EIEN) begin
      rd_d[7:0] = eien_q;
    end else if (paddr == `UDOC_OFF_IFLG) begin
      rd_d[7:0] = iflg_q;
    end else if (paddr == `UDOC_OFF_EIFLG) begin
      rd_d[7:0] = eiflg_q;
    end else if (paddr == `UDOC_OFF_EP0) begin
      rd_d[7:0] = ep0_q;
    end else if (paddr == `UDOC_OFF_PWR) begin
      rd_d[7:0] = pwr_q;
    end else if (paddr == `UDOC_OFF_PINS) begin
      rd_d[0] = sy2_q[16];
    end else begin
      err_d = 1'b1;
    end
  end

  // Outputs are registered; pready answers one cycle into the access phase.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      dplus_pullup_en <= 1'b0;
      dminus_pullup_en <= 1'b0;
      dplus_pulldown_en <= 1'b0;
      dminus_pulldown_en <= 1'b0;
      vbus_discharge_en <= 1'b0;
      pingpong_ptr_reset <= 1'b0;
      usb_module_on <= 1'b0;
      usb_power_on <= 1'b0;
      endpoint_rx_allow <= 1'b0;
      endpoint_handshake_on <= 1'b0;
      usb_irq <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rd_d : 32'h00000000;
      pslverr <= psel & penable & ~pready & err_d;
      dplus_pullup_en <= pu_dp;
      dminus_pullup_en <= pu_dm;
      dplus_pulldown_en <= pd_dp;
      dminus_pulldown_en <= pd_dm;
      vbus_discharge_en <= otg_q[`UDOC_OTG_VDIS];
      pingpong_ptr_reset <= ctrl_q[`UDOC_CTRL_PPRST];
      usb_module_on <= ctrl_q[`UDOC_CTRL_ON];
      usb_power_on <= pwr_q[`UDOC_PWR_ON];
      endpoint_rx_allow <= ep0_q[`UDOC_EP0_RX];
      endpoint_handshake_on <= ep0_q[`UDOC_EP0_HSHK];
      usb_irq <= |((iflg_q & ien_q) | (eiflg_q & eien_q));
    end
  end
endmodule // udoc_top
`default_nettype wire

// >>> udoc_defs.vh
// Register map, field positions and reset values of the USB pull control block.
`ifndef UDOC_DEFS_VH
`define UDOC_DEFS_VH
`define UDOC_OFF_CTRL 12'h000
`define UDOC_OFF_OTG 12'h004
`define UDOC_OFF_IEN 12'h008
`define UDOC_OFF_EIEN 12'h00c
`define UDOC_OFF_IFLG 12'h010
`define UDOC_OFF_EIFLG 12'h014
`define UDOC_OFF_EP0 12'h018
`define UDOC_OFF_PWR 12'h01c
`define UDOC_OFF_PINS 12'h020
`define UDOC_CTRL_ON 0
`define UDOC_CTRL_PPRST 1
`define UDOC_CTRL_HOST 3
`define UDOC_OTG_VDIS 0
`define UDOC_OTG_OTG_FEATURES_ON 2
`define UDOC_OTG_DMPD 4
`define UDOC_OTG_DPPD 5
`define UDOC_OTG_DMPU 6
`define UDOC_OTG_DPPU 7
`define UDOC_OTG_WMASK 8'hf5
`define UDOC_EP0_HSHK 0
`define UDOC_EP0_RX 3
`define UDOC_PWR_ON 0
`define UDOC_RST8 8'h00
`endif

// >>> udoc_host_model.sv
// Host line model that resolves the D+ and D- levels.
`timescale 1ns/1ps
`default_nettype none
module udoc_host_model (
  input wire logic dplus_pullup_en, dminus_pullup_en,
  input wire logic dplus_pulldown_en, dminus_pulldown_en,
  output logic dp, dm
);
  assign dp = dplus_pullup_en && !dplus_pulldown_en;
  assign dm = dminus_pullup_en && !dminus_pulldown_en;
endmodule // udoc_host_model
`default_nettype wire

// >>> udoc_monitor.sv
// Checker of the pull network and register read-back.
`timescale 1ns/1ps
`default_nettype none
module udoc_monitor (
  input wire pclk, presetn, psel, penable, pwrite, pready,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en,
  input wire dminus_pulldown_en, vbus_discharge_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire hit = psel && penable && pready && paddr == 12'h4;
  wire [1:0] pu = {dplus_pullup_en, dminus_pullup_en};
  wire [1:0] pd = {dplus_pulldown_en, dminus_pulldown_en};
  sequence otg_wr; hit && pwrite; endsequence
  sequence otg_rd; hit && !pwrite; endsequence
  chk_pu_map: assert property (
    otg_wr ##0 pwdata[2] |-> ##2 pu == $past(pwdata[7:6], 2))
    else $error("pull-up");
  chk_pd_map: assert property (
    otg_wr ##0 pwdata[2] |-> ##2 pd == $past(pwdata[5:4], 2))
    else $error("pull-down");
  chk_hw_pull: assert property (
    otg_wr ##0 !pwdata[2] |-> ##2 !pu[0] && !(pu[1] && pd[1]))
    else $error("hardware pulls");
  chk_vbus_map: assert property (
    otg_wr |-> ##2 vbus_discharge_en == $past(pwdata[0], 2))
    else $error("discharge");
  chk_upper_zero: assert property (
    otg_rd |-> prdata[31:8] == 24'h0) else $error("upper byte");
  chk_rsvd_zero: assert property (
    otg_rd |-> !prdata[3] && !prdata[1]) else $error("reserved");
  chk_rst_idle: assert property (
    $rose(presetn) |-> !pu && !pd && !vbus_discharge_en)
    else $error("reset pulls");
  chk_pull_hold: assert property (
    !psel [*3] |-> $stable(pu) && $stable(pd)) else $error("drift");
endmodule // udoc_monitor
bind udoc_top udoc_monitor udoc_monitor_i (.*);
`default_nettype wire

// >>> udoc_top_tb_top.sv
// Register-level testbench of the USB pull control block.
`timescale 1ns/1ps
`default_nettype none
module udoc_top_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, usb_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] usb_event_in, usb_err_event_in;
  logic vbus_present_in, dplus_pullup_en, dminus_pullup_en, dp, dm;
  logic dplus_pulldown_en, dminus_pulldown_en, vbus_discharge_en;
  logic pingpong_ptr_reset, usb_module_on, usb_power_on, er;
  logic endpoint_rx_allow, endpoint_handshake_on;
  int mismatches, n_checks, cyc;
  wire [4:0] pins = {dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en,
    dminus_pulldown_en, vbus_discharge_en};
  wire [4:0] ctl = {pingpong_ptr_reset, usb_module_on, usb_power_on,
    endpoint_rx_allow, endpoint_handshake_on};
  udoc_top udoc_top_i (.*);
  udoc_host_model udoc_host_model_i (.*);
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      test_done;
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task ck(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    repeat (2) @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    ap(1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    ap(0, a, 32'h0);
    ck(r, e);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = 0;
    {usb_event_in, usb_err_event_in} = 16'h0;
    vbus_present_in = 1;
    presetn = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rd(12'h4, 32'h0);
    ck(pins, 32'h0);
    wr(12'h0, 32'h2);
    ck(ctl, 32'h10);
    wr(12'h0, 32'h0);
    wr(12'h8, 32'h0);
    wr(12'hc, 32'h0);
    wr(12'h10, 32'hff);
    wr(12'h14, 32'hff);
    rd(12'h20, 32'h1);
    wr(12'h0, 32'h1);
    wr(12'h4, 32'h4);
    wr(12'h18, 32'h9);
    wr(12'h1c, 32'h1);
    wr(12'h4, 32'h84);
    ck(ctl, 32'hf);
    ck({dp, dm}, 32'h2);
    wr(12'h4, 32'hffff);
    rd(12'h4, 32'hf5);
    ck(pins, 32'h1f);
    wr(12'h4, 32'h41);
    ck(pins, 32'h11);
    wr(12'h0, 32'h9);
    ck(pins, 32'h7);
    wr(12'h8, 32'h1);
    @(posedge pclk);
    usb_event_in <= 8'h1;
    usb_err_event_in <= 8'h2;
    @(posedge pclk);
    {usb_event_in, usb_err_event_in} <= 16'h0;
    repeat (5) @(posedge pclk);
    ck(usb_irq, 32'h1);
    rd(12'h14, 32'h2);
    wr(12'h10, 32'h0);
    rd(12'h10, 32'h1);
    wr(12'h10, 32'hff);
    rd(12'h10, 32'h0);
    ck(usb_irq, 32'h0);
    rd(12'h40, 32'h0);
    ck(er, 32'h1);
    test_done;
  end
endmodule // udoc_top_tb_top
`default_nettype wire
